// ---- core/dhi_host_port.sv ----
// display module host port: mode select, parallel transfers, init on reset
`timescale 1ns/100ps
`default_nettype none
module dhi_host_port
    import dhi_pkg::*;
#(
    parameter int INIT_LEN = INIT_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // interface selection straps
    input wire logic bus_select_low_i,
    input wire logic bus_select_high_i,
    // host control pins
    input wire logic cs_n_i,
    input wire logic reset_n_i,
    input wire logic dc_i,
    input wire logic rw_i,
    input wire logic en_i,
    // bidirectional data bus
    input wire logic [7:0] d_i,
    output logic [7:0] d_o,
    output logic d_oe_n_o,
    // core side: read data source
    input wire logic [7:0] rd_data_i,
    output logic rd_req_o,
    output logic rd_is_data_o,
    // core side: written bytes
    output logic [7:0] cmd_o,
    output logic cmd_valid_o,
    output logic [7:0] pix_o,
    output logic pix_valid_o,
    // status
    output dhi_mode_t mode_o,
    output logic slave_addr_lsb_o,
    output logic init_busy_o
);
    if (INIT_LEN < 1 || INIT_LEN > 65535)
    begin : g_bad_init_len
        $error("INIT_LEN out of range");
    end

    typedef enum logic [1:0] {
        ST_INIT,
        ST_IDLE,
        ST_WRITE,
        ST_READ
    } dhi_state_t;

    dhi_state_t state;
    dhi_state_t next_state;
    logic [15:0] init_cnt;
    logic [15:0] next_init_cnt;
    logic dc_hold;
    logic next_dc_hold;
    logic [7:0] next_d_o;
    logic next_d_oe_n;
    logic next_rd_req;
    logic next_rd_is_data;
    logic [7:0] next_cmd;
    logic next_cmd_valid;
    logic [7:0] next_pix;
    logic next_pix_valid;
    dhi_mode_t next_mode;
    logic next_sa_lsb;
    logic next_init_busy;

    logic stb_start;
    logic stb_end;
    logic stb_read;
    logic [7:0] stb_wdata;

    dhi_strobe u_strobe (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .mode_i(mode_o),
        .cs_n_i(cs_n_i),
        .rw_i(rw_i),
        .en_i(en_i),
        .d_i(d_i),
        .start_o(stb_start),
        .end_o(stb_end),
        .is_read_o(stb_read),
        .wdata_o(stb_wdata)
    );

    always_comb
    begin
        next_state = state;
        next_init_cnt = init_cnt;
        next_dc_hold = dc_hold;
        next_d_o = d_o;
        next_d_oe_n = 1'b1;
        next_rd_req = 1'b0;
        next_rd_is_data = rd_is_data_o;
        next_cmd = cmd_o;
        next_cmd_valid = 1'b0;
        next_pix = pix_o;
        next_pix_valid = 1'b0;
        next_mode = dhi_decode_mode(bus_select_low_i,
                                    bus_select_high_i);
        next_sa_lsb = slave_addr_lsb_o;
        next_init_busy = 1'b0;

        if (next_mode == DHI_MODE_I2C)
            next_sa_lsb = dc_i;

        case (state)
            ST_INIT:
            begin
                next_init_busy = 1'b1;
                next_cmd = RST_CMD;
                next_pix = RST_DATA;
                if (init_cnt == 16'(INIT_LEN - 1))
                begin
                    next_state = ST_IDLE;
                    next_init_busy = 1'b0;
                end
                else
                    next_init_cnt = init_cnt + 16'h0001;
            end
            ST_IDLE:
            begin
                if (stb_start && !cs_n_i && dhi_is_parallel(mode_o))
                begin
                    next_dc_hold = dc_i;
                    if (stb_read)
                    begin
                        next_state = ST_READ;
                        next_rd_req = 1'b1;
                        next_rd_is_data = dc_i;
                    end
                    else
                        next_state = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                if (cs_n_i)
                    next_state = ST_IDLE;
                else if (stb_end)
                begin
                    next_state = ST_IDLE;
                    if (dc_hold)
                    begin
                        next_pix = stb_wdata;
                        next_pix_valid = 1'b1;
                    end
                    else
                    begin
                        next_cmd = stb_wdata;
                        next_cmd_valid = 1'b1;
                    end
                end
            end
            ST_READ:
            begin
                if (cs_n_i || stb_end)
                    next_state = ST_IDLE;
                else
                begin
                    next_d_o = rd_data_i;
                    next_d_oe_n = 1'b0;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase

        if (!reset_n_i)
        begin
            next_state = ST_INIT;
            next_init_cnt = 16'h0000;
            next_init_busy = 1'b1;
            next_d_oe_n = 1'b1;
            next_cmd_valid = 1'b0;
            next_pix_valid = 1'b0;
            next_rd_req = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= ST_INIT;
            init_cnt <= 16'h0000;
            dc_hold <= 1'b0;
            d_o <= RST_BUS;
            d_oe_n_o <= 1'b1;
            rd_req_o <= 1'b0;
            rd_is_data_o <= 1'b0;
            cmd_o <= RST_CMD;
            cmd_valid_o <= 1'b0;
            pix_o <= RST_DATA;
            pix_valid_o <= 1'b0;
            mode_o <= DHI_MODE_SERIAL;
            slave_addr_lsb_o <= 1'b0;
            init_busy_o <= 1'b1;
        end
        else
        begin
            state <= next_state;
            init_cnt <= next_init_cnt;
            dc_hold <= next_dc_hold;
            d_o <= next_d_o;
            d_oe_n_o <= next_d_oe_n;
            rd_req_o <= next_rd_req;
            rd_is_data_o <= next_rd_is_data;
            cmd_o <= next_cmd;
            cmd_valid_o <= next_cmd_valid;
            pix_o <= next_pix;
            pix_valid_o <= next_pix_valid;
            mode_o <= next_mode;
            slave_addr_lsb_o <= next_sa_lsb;
            init_busy_o <= next_init_busy;
        end
    end

endmodule
`default_nettype wire

// ---- core/dhi_pkg.sv ----
// constants and types shared by the display host port design
// Notes on behaviour
// - two static selects pick 6800, 8080, serial or I2C as host bus.
// - transfers are answered while chip select is low, ignored when high.
// - a low reset pin runs init; the host keeps it high in normal use.
// - with the data/command selector high a byte is display data.
// - with the data/command selector low a written byte is a command.
// - in I2C mode the data/command selector is the slave address lsb.
// - in 6800 mode direction high reads and low writes, set before strobe.
// - in 6800 mode a selected cycle starts when the enable rises.
// - in 8080 mode a selected write starts when the direction pin falls.
// - in 8080 mode a selected read starts when the enable pin falls.
package dhi_pkg;

    typedef enum logic [1:0] {
        DHI_MODE_6800,
        DHI_MODE_8080,
        DHI_MODE_SERIAL,
        DHI_MODE_I2C
    } dhi_mode_t;

    // select pair {bus_select_high, bus_select_low}
    localparam logic [1:0] SEL_6800 = 2'h2;
    localparam logic [1:0] SEL_8080 = 2'h3;
    localparam logic [1:0] SEL_SERIAL = 2'h0;
    localparam logic [1:0] SEL_I2C = 2'h1;

    localparam int CLK_FREQ_KHZ = 20000;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES =
        (INIT_TIME_NS * CLK_FREQ_KHZ + 999999) / 1000000;

    localparam logic [7:0] RST_CMD = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_BUS = 8'h00;

    function automatic dhi_mode_t dhi_decode_mode(input logic sel_low,
                                                 input logic sel_high);
        logic [1:0] pair;
        pair = {sel_high, sel_low};
        case (pair)
            SEL_6800: dhi_decode_mode = DHI_MODE_6800;
            SEL_8080: dhi_decode_mode = DHI_MODE_8080;
            SEL_I2C: dhi_decode_mode = DHI_MODE_I2C;
            default: dhi_decode_mode = DHI_MODE_SERIAL;
        endcase
    endfunction

    function automatic logic dhi_is_parallel(input dhi_mode_t mode);
        dhi_is_parallel = (mode == DHI_MODE_6800) || (mode == DHI_MODE_8080);
    endfunction

endpackage

// ---- core/dhi_strobe.sv ----
// strobe decoder: turns the parallel control pins into start and end pulses
`timescale 1ns/100ps
`default_nettype none
module dhi_strobe
    import dhi_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // pins and mode
    input wire dhi_mode_t mode_i,
    input wire logic cs_n_i,
    input wire logic rw_i,
    input wire logic en_i,
    input wire logic [7:0] d_i,
    // decoded events
    output logic start_o,
    output logic end_o,
    output logic is_read_o,
    output logic [7:0] wdata_o
);
    logic active;
    logic rd_active;
    logic prev_active;
    logic next_prev_active;
    logic next_start;
    logic next_end;
    logic next_is_read;
    logic [7:0] next_wdata;

    always_comb
    begin
        case (mode_i)
            DHI_MODE_6800:
            begin
                active = en_i;
                rd_active = rw_i;
            end
            DHI_MODE_8080:
            begin
                active = !rw_i || !en_i;
                rd_active = !en_i;
            end
            default:
            begin
                active = 1'b0;
                rd_active = 1'b0;
            end
        endcase
        next_prev_active = active;
        next_start = active && !prev_active && !cs_n_i;
        next_end = !active && prev_active;
        next_is_read = next_start ? rd_active : is_read_o;
        next_wdata = (active && !cs_n_i) ? d_i : wdata_o;
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prev_active <= 1'b0;
            start_o <= 1'b0;
            end_o <= 1'b0;
            is_read_o <= 1'b0;
            wdata_o <= RST_BUS;
        end
        else
        begin
            prev_active <= next_prev_active;
            start_o <= next_start;
            end_o <= next_end;
            is_read_o <= next_is_read;
            wdata_o <= next_wdata;
        end
    end

endmodule
`default_nettype wire

// ---- sim/dhi_port_properties.sv ----
// concurrent checks on the display host port pins
`timescale 1ns/100ps
`default_nettype none
module dhi_port_chk
    import dhi_pkg::*;
#(
    parameter int INIT_LEN = 2
)
(
    // clock, reset and pins
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic bus_select_low_i,
    input wire logic bus_select_high_i,
    input wire logic cs_n_i,
    input wire logic reset_n_i,
    input wire logic dc_i,
    input wire logic rw_i,
    input wire logic en_i,
    // outputs watched
    input wire logic d_oe_n_o,
    input wire logic rd_req_o,
    input wire logic cmd_valid_o,
    input wire logic pix_valid_o,
    input wire dhi_mode_t mode_o,
    input wire logic slave_addr_lsb_o,
    input wire logic init_busy_o
);
    localparam int BUSY_MAX = INIT_LEN + 2;
    dhi_mode_t exp_mode;
    logic ev;
    assign exp_mode = bus_select_high_i
        ? (bus_select_low_i ? DHI_MODE_8080 : DHI_MODE_6800)
        : (bus_select_low_i ? DHI_MODE_I2C : DHI_MODE_SERIAL);
    assign ev = cmd_valid_o || pix_valid_o || rd_req_o;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
    chk_mode_map: assert property (1'b1 |=> mode_o == $past(exp_mode))
        else $error("mode does not follow straps");
    chk_cs_quiet: assert property (cs_n_i [*3] |-> !ev && d_oe_n_o)
        else $error("activity while deselected");
    chk_init_quiet: assert property (init_busy_o |-> !ev)
        else $error("transfer during init");
    chk_init_start: assert property (!reset_n_i [*2] |=> init_busy_o)
        else $error("reset pin did not start init");
    chk_init_len: assert property ($rose(reset_n_i) |-> init_busy_o
        ##[1:BUSY_MAX] !init_busy_o) else $error("init length wrong");
    chk_dc_route: assert property (cmd_valid_o || pix_valid_o |->
        pix_valid_o == dc_i && cmd_valid_o == !dc_i)
        else $error("byte routed by wrong selector");
    chk_sa_copy: assert property (exp_mode == DHI_MODE_I2C |=>
        slave_addr_lsb_o == $past(dc_i)) else $error("address bit stale");
    chk_w6800_end: assert property ((!cs_n_i && en_i && !rw_i
        && mode_o == DHI_MODE_6800 && !init_busy_o) [*4] ##1 !en_i
        |-> ##[1:3] (cmd_valid_o || pix_valid_o)) else $error("write lost");
    chk_r8080_drive: assert property (!cs_n_i && rw_i && $fell(en_i)
        && mode_o == DHI_MODE_8080 && !init_busy_o
        |-> ##[1:3] rd_req_o ##1 !d_oe_n_o) else $error("read not driven");
    cov_cmd: cover property (cmd_valid_o);
    cov_pix: cover property (pix_valid_o);
    cov_read: cover property (rd_req_o ##1 !d_oe_n_o);
endmodule
bind dhi_host_port dhi_port_chk #(.INIT_LEN(INIT_LEN)) chk (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
    .bus_select_low_i(bus_select_low_i), .dc_i(dc_i), .rw_i(rw_i),
    .bus_select_high_i(bus_select_high_i), .reset_n_i(reset_n_i),
    .en_i(en_i), .d_oe_n_o(d_oe_n_o), .rd_req_o(rd_req_o),
    .cmd_valid_o(cmd_valid_o), .pix_valid_o(pix_valid_o),
    .mode_o(mode_o), .slave_addr_lsb_o(slave_addr_lsb_o),
    .init_busy_o(init_busy_o));
`default_nettype wire

// ---- sim/dhi_host_model.sv ----
// host processor model for the parallel display port
`timescale 1ns/100ps
`default_nettype none
module dhi_host_model
(
    // clock and resolved bus
    input wire logic clk_i,
    input wire logic [7:0] bus_i,
    // pins toward the device
    output logic cs_n_o,
    output logic dc_o,
    output logic rw_o,
    output logic en_o,
    output logic [7:0] d_o
);
    initial
    begin
        {cs_n_o, dc_o, rw_o, en_o} = 4'h8;
        d_o = 8'h00;
    end
    // one transfer; m80 picks 8080 strobes, rd a read
    task automatic xfer(input logic m80, rd, cs, dc, input logic [7:0] wd,
                        output logic [7:0] rv);
        @(negedge clk_i);
        {cs_n_o, dc_o} = {cs, dc};
        d_o = rd ? ~d_o : wd;
        rw_o = m80 | rd;
        @(negedge clk_i);
        if (!m80)
            en_o = 1'b1;
        else if (rd)
            en_o = 1'b0;
        else
            rw_o = 1'b0;
        repeat (6) @(negedge clk_i);
        rv = bus_i;
        {rw_o, en_o} = {m80, m80};
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        d_o = ~d_o; // no stale byte once released
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench for the display host port
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import dhi_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic sl = 1'b0;
    logic sh = 1'b1;
    logic rst_pin = 1'b1;
    logic [7:0] rdd = 8'h5A;
    logic cs_n, dc, rw, en, oe_n, rq, rdc, cv, pv, sa, busy;
    logic [7:0] hd, dq, cmd, pix, rv;
    dhi_mode_t mode;
    wire logic [7:0] bus = oe_n ? hd : dq;
    int fail_count = 0;
    int samples_checked = 0;
    int n_cmd = 0, n_pix = 0, n_rd = 0, cyc = 0;
    dhi_host_port #(.INIT_LEN(2)) uut (
        .sys_clk_i(clk), .rstn_i(rstn), .bus_select_low_i(sl),
        .bus_select_high_i(sh), .cs_n_i(cs_n), .reset_n_i(rst_pin),
        .dc_i(dc), .rw_i(rw), .en_i(en), .d_i(bus), .d_o(dq),
        .d_oe_n_o(oe_n), .rd_data_i(rdd), .rd_req_o(rq),
        .rd_is_data_o(rdc), .cmd_o(cmd), .cmd_valid_o(cv), .pix_o(pix),
        .pix_valid_o(pv), .mode_o(mode), .slave_addr_lsb_o(sa),
        .init_busy_o(busy));
    dhi_host_model host (.clk_i(clk), .bus_i(bus), .cs_n_o(cs_n),
        .dc_o(dc), .rw_o(rw), .en_o(en), .d_o(hd));
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        n_cmd += int'(cv === 1'b1);
        n_pix += int'(pv === 1'b1);
        n_rd += int'(rq === 1'b1);
        cyc++;
        if (cyc == 3000)
        begin
            fail_count++;
            report_and_stop;
        end
    end
    task automatic ck(input string what, input logic [7:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic t_reset;
        ck("busy", 8'(busy), 8'h01);
        repeat (6) @(negedge clk);
        ck("busy", 8'(busy), 8'h00);
        ck("oe_n", 8'(oe_n), 8'h01);
        ck("mode", 8'(mode), 8'(DHI_MODE_6800));
        $display("test reset done");
    endtask
    task automatic t_6800;
        host.xfer(1'b0, 1'b0, 1'b0, 1'b0, 8'hA5, rv);
        host.xfer(1'b0, 1'b0, 1'b0, 1'b1, 8'h3C, rv);
        host.xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h77, rv);
        ck("cmd", cmd, 8'hA5);
        ck("pix", pix, 8'h3C);
        ck("n_cmd", n_cmd[7:0], 8'h01);
        host.xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, rv);
        ck("rdata", rv, 8'h5A);
        ck("rd_dc", 8'(rdc), 8'h01);
        ck("n_pix", n_pix[7:0], 8'h01);
        ck("oe_n", 8'(oe_n), 8'h01);
        $display("test 6800 done");
    endtask
    task automatic t_8080;
        sl = 1'b1;
        host.xfer(1'b1, 1'b0, 1'b1, 1'b0, 8'h00, rv);
        ck("mode", 8'(mode), 8'(DHI_MODE_8080));
        host.xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hC3, rv);
        ck("cmd", cmd, 8'hC3);
        rdd = 8'h96;
        host.xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, rv);
        ck("rdata", rv, 8'h96);
        ck("n_rd", n_rd[7:0], 8'h02);
        $display("test 8080 done");
    endtask
    task automatic t_modes;
        sl = 1'b0;
        host.xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, rv);
        sh = 1'b0;
        repeat (2) @(negedge clk);
        ck("mode", 8'(mode), 8'(DHI_MODE_SERIAL));
        sl = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            host.xfer(1'b0, 1'b0, 1'b0, i == 0, 8'h00, rv);
            ck("sa", 8'(sa), 8'(i == 0));
        end
        ck("n_cmd", n_cmd[7:0], 8'h02);
        ck("n_pix", n_pix[7:0], 8'h01);
        ck("mode", 8'(mode), 8'(DHI_MODE_I2C));
        sh = 1'b1;
        sl = 1'b0;
        $display("test modes done");
    endtask
    task automatic t_init;
        rst_pin = 1'b0;
        repeat (3) @(negedge clk);
        ck("busy", 8'(busy), 8'h01);
        ck("cmd", cmd, 8'h00);
        rst_pin = 1'b1;
        repeat (6) @(negedge clk);
        ck("busy", 8'(busy), 8'h00);
        $display("test init done");
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        rstn = 1'b1;
        t_reset;
        t_6800;
        t_8080;
        t_modes;
        t_init;
        report_and_stop;
    end
endmodule
`default_nettype wire
